/* File: core/osi_core.sv */
// otp security word, programming ports, test-port id/usercode and debug pin
// ************************************
// module
// ************************************
// Contract
// - otp is four sectors of 512 rows of 32-bit words
// - security word loaded from otp before any feature takes effect
// - remaining otp content copied to sram and run first
// - programming uses 16-bit address, 32-bit data, 16-bit control ports
// - bit 0 refuses all test-port access to tile state and memory; the code gates only tap_grant_q, test-port otp reads follow bit 13 alone
// - bit 1 denies other tiles access through the switch
// - bit 5 bypasses boot rom and boots from otp address zero
// - bit 7 enables redundant otp rows
// - bits 8 to 11 lock programming of sectors 0 to 3
// - bit 12 blocks all programming including the security word
// - bit 13 blocks test-port reads and writes of the otp
// - bit 14 disables the debug synchronisation pin entirely
// - bits 15 to 21 are user bits readable by software
// - usercode user-id comes from security bits 22 to 31
// - two taps each with 4-bit instruction and 32-bit data register
// - output mode: pin released until breakpoint, then driven low
// - input mode: low on the pin puts the tile in debug
// - test_port_identification is version, part, maker fields with bit 0 one
// - usercode is user-id, unused field and silicon revision
// - without secure boot the tile boots from internal flash
module osi_core #(
  parameter int unsigned SECTORS = osi_pkg::SECTORS,
  parameter int unsigned ROWS = osi_pkg::ROWS_PER_SECTOR
) (
  input wire logic clk_sys, // tile clock
  input wire logic rst, // global reset, async high
  input wire osi_pkg::osi_prog_req_t prog_req, // port write: addr, data, ctrl
  input wire logic [23:0] prog_res_id, // resource id of the port written
  input wire logic tap_trst_n, // test-port reset, low active
  input wire logic [3:0] tap_ir, // instruction from the tap
  input wire logic tap_capture, // capture data register strobe
  input wire logic tap_sel, // 0 or 1: which boundary tap
  input wire logic tap_state_req, // test-port request for tile state
  input wire logic link_state_req, // other tile request for state
  input wire logic brk_hit, // processor hit a breakpoint
  input wire logic dbg_out_mode, // debug pin configured as output
  input wire logic dbg_in_mode, // debug pin configured as input
  input wire logic dbg_pin_i, // debug pin level in
  output logic dbg_pin_o_q, // debug pin drive value
  output logic dbg_pin_oe_q, // debug pin output enable
  output logic debug_enter_q, // tile entering debug mode pulse
  output logic [31:0] tap_dr_q, // captured 32-bit data register
  output logic tap_grant_q, // test-port state access granted
  output logic link_grant_q, // link state access granted
  output logic [31:0] sec_word_q, // loaded security word
  output logic sec_ready_q, // security word loaded
  output logic boot_from_otp_q, // boot path select: otp
  output logic boot_from_flash_q, // boot path select: flash
  output logic copy_done_q, // otp image copied to sram
  output logic [31:0] copy_data_q, // word going to sram
  output logic [15:0] copy_addr_q, // sram word address
  output logic copy_we_q, // sram write strobe
  output logic [31:0] prog_rdata_q, // otp read data
  output logic prog_err_q // last programming or read command refused
);
  localparam int unsigned AW = $clog2(SECTORS * ROWS);
  localparam int unsigned SW = $clog2(SECTORS);
  localparam int unsigned RW = $clog2(ROWS);
  typedef enum logic [1:0] {OSI_LOAD, OSI_COPY, OSI_RUN} osi_st_t;

  // ************************************
  // storage
  // ************************************
  // fuse cells keep their content across resets; erased cells read as zero
  logic [31:0] otp_mem [SECTORS * ROWS] = '{default: 32'h0000_0000};
  logic [31:0] red_mem [SECTORS] = '{default: 32'h0000_0000}; // one redundant row per sector
  logic [31:0] sec_fuse_q = 32'h0000_0000;
  osi_st_t st_q;
  logic [AW:0] cnt_q;
  logic [15:0] addr_q;
  logic [7:0] trst_cnt_q;
  logic dbg_prev_q;

  // sector of a port address
  function automatic logic [SW-1:0] sec_of(input logic [15:0] a);
    sec_of = a[RW +: SW];
  endfunction : sec_of

  wire logic is_addr = prog_req.valid && prog_res_id == osi_pkg::RES_OTP_ADDR;
  wire logic is_data = prog_req.valid && prog_res_id == osi_pkg::RES_OTP_DATA;
  wire logic is_ctrl = prog_req.valid && prog_res_id == osi_pkg::RES_OTP_CTRL;
  wire logic lock_hit = sec_word_q[osi_pkg::SEC_MASTER_LOCK]
    || sec_word_q[osi_pkg::SEC_SECTOR_LOCK_LO + 32'(sec_of(addr_q))];
  wire logic red_sel = sec_word_q[osi_pkg::SEC_REDUNDANT] && (addr_q[RW-1:0] == '1);
  wire logic otp_port_ok = sec_ready_q && !sec_word_q[osi_pkg::SEC_NO_TEST_OTP];
  logic [31:0] data_q;

  // ************************************
  // load, copy, run sequence
  // ************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= OSI_LOAD;
      cnt_q <= '0;
      sec_word_q <= osi_pkg::SEC_RESET;
      sec_ready_q <= 1'b0;
      copy_done_q <= 1'b0;
      copy_we_q <= 1'b0;
      copy_data_q <= '0;
      copy_addr_q <= '0;
      boot_from_otp_q <= 1'b0;
      boot_from_flash_q <= 1'b0;
    end
    else
    begin
      copy_we_q <= 1'b0;
      unique case (st_q)
        OSI_LOAD:
        begin
          sec_word_q <= sec_fuse_q;
          sec_ready_q <= 1'b1;
          st_q <= OSI_COPY;
        end
        OSI_COPY:
        begin
          copy_we_q <= 1'b1;
          copy_data_q <= otp_mem[cnt_q[AW-1:0]];
          copy_addr_q <= 16'(cnt_q);
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == (AW + 1)'(SECTORS * ROWS - 1))
          begin
            st_q <= OSI_RUN;
            copy_done_q <= 1'b1;
            boot_from_otp_q <= sec_word_q[osi_pkg::SEC_SECURE_BOOT];
            boot_from_flash_q <= !sec_word_q[osi_pkg::SEC_SECURE_BOOT];
          end
        end
        OSI_RUN: st_q <= OSI_RUN;
      endcase
    end
  end

  // ************************************
  // programming ports
  // ************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= '0;
      data_q <= '0;
      prog_err_q <= 1'b0;
      prog_rdata_q <= '0;
    end
    else
    begin
      if (is_addr)
        addr_q <= prog_req.addr;
      if (is_data)
        data_q <= prog_req.data;
      if (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG)
        prog_err_q <= !otp_port_ok || lock_hit;
      else if (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG_SEC)
        prog_err_q <= !otp_port_ok || sec_word_q[osi_pkg::SEC_MASTER_LOCK];
      else if (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_READ)
      begin
        prog_err_q <= !otp_port_ok;
        if (otp_port_ok)
          prog_rdata_q <= red_sel ? red_mem[sec_of(addr_q)] : otp_mem[addr_q[AW-1:0]];
        else
          prog_rdata_q <= '0;
      end
    end
  end

  // otp cells only gain ones: fuse model, no reset
  always_ff @(posedge clk_sys)
  begin
    if (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG && otp_port_ok && !lock_hit)
    begin
      if (red_sel)
        red_mem[sec_of(addr_q)] <= red_mem[sec_of(addr_q)] | data_q;
      else
        otp_mem[addr_q[AW-1:0]] <= otp_mem[addr_q[AW-1:0]] | data_q;
    end
  end

  // security fuses burn only without master lock; effect after next power up
  always_ff @(posedge clk_sys)
  begin
    if (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG_SEC && otp_port_ok
        && !sec_word_q[osi_pkg::SEC_MASTER_LOCK])
      sec_fuse_q <= sec_fuse_q | data_q;
  end

  // ************************************
  // access gates
  // ************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tap_grant_q <= 1'b0;
      link_grant_q <= 1'b0;
    end
    else
    begin
      tap_grant_q <= tap_state_req && sec_ready_q && trst_cnt_q == 8'(osi_pkg::TRST_MIN_CYC)
        && !sec_word_q[osi_pkg::SEC_NO_TEST];
      link_grant_q <= link_state_req && sec_ready_q && !sec_word_q[osi_pkg::SEC_NO_LINK];
    end
  end

  // ************************************
  // test-port registers
  // ************************************
  // test reset counter: logic stays in reset while low, and min width
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      trst_cnt_q <= '0;
    else if (!tap_trst_n)
      trst_cnt_q <= '0;
    else if (trst_cnt_q != 8'(osi_pkg::TRST_MIN_CYC))
      trst_cnt_q <= trst_cnt_q + 8'h01;
  end

  // data register capture for either boundary tap
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      tap_dr_q <= '0;
    else if (trst_cnt_q != 8'(osi_pkg::TRST_MIN_CYC))
      tap_dr_q <= '0;
    else if (tap_capture)
    begin
      unique case (tap_ir)
        osi_pkg::IR_TEST_PORT_IDENTIFICATION:
          tap_dr_q <= {osi_pkg::ID_VERSION, osi_pkg::ID_PART, osi_pkg::ID_MAKER, 1'b1};
        osi_pkg::IR_USERCODE:
          tap_dr_q <= {sec_word_q[osi_pkg::SEC_USER_HI:osi_pkg::SEC_USER_LO], 6'h00,
                       osi_pkg::SILICON_REV};
        osi_pkg::IR_OTP_READ:
          tap_dr_q <= otp_port_ok ? otp_mem[addr_q[AW-1:0]] : 32'h0000_0000;
        default:
          tap_dr_q <= {31'h0000_0000, tap_sel};
      endcase
    end
  end

  // ************************************
  // debug pin
  // ************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dbg_pin_o_q <= 1'b0;
      dbg_pin_oe_q <= 1'b0;
      debug_enter_q <= 1'b0;
      dbg_prev_q <= 1'b1;
    end
    else
    begin
      dbg_prev_q <= dbg_pin_i;
      dbg_pin_o_q <= 1'b0;
      if (!sec_ready_q || sec_word_q[osi_pkg::SEC_NO_DEBUG_PIN])
      begin
        dbg_pin_oe_q <= 1'b0;
        debug_enter_q <= 1'b0;
      end
      else
      begin
        if (!dbg_out_mode)
          dbg_pin_oe_q <= 1'b0;
        else if (brk_hit)
          dbg_pin_oe_q <= 1'b1;
        debug_enter_q <= dbg_in_mode && !dbg_pin_i && dbg_prev_q;
      end
    end
  end

  // ************************************
  // assertions
  // ************************************
  AST_LOCKED_PROG_ERR: assert property (@(posedge clk_sys) disable iff (rst)
    (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG && lock_hit) |=> prog_err_q)
    else $error("locked sector programming not refused");
  AST_MASTER_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
    (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG_SEC && sec_word_q[osi_pkg::SEC_MASTER_LOCK])
    |=> prog_err_q) else $error("security programming not refused under master lock");
  AST_LOCK_NOCHANGE: assert property (@(posedge clk_sys) disable iff (rst)
    (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG && lock_hit && !red_sel)
    |=> otp_mem[$past(addr_q[AW-1:0])] == $past(otp_mem[addr_q[AW-1:0]]))
    else $error("locked otp word changed");
  AST_NO_TEST: assert property (@(posedge clk_sys) disable iff (rst)
    sec_word_q[osi_pkg::SEC_NO_TEST] |=> !tap_grant_q) else $error("test access granted while disabled");
  AST_NO_LINK: assert property (@(posedge clk_sys) disable iff (rst)
    (sec_ready_q && link_state_req && !sec_word_q[osi_pkg::SEC_NO_LINK]) |=> link_grant_q)
    else $error("link access wrongly refused");
  AST_BOOT_SEL: assert property (@(posedge clk_sys) disable iff (rst)
    copy_done_q |-> (boot_from_otp_q == sec_word_q[osi_pkg::SEC_SECURE_BOOT])
      && (boot_from_flash_q != boot_from_otp_q)) else $error("boot path wrong");
  AST_TEST_OTP: assert property (@(posedge clk_sys) disable iff (rst)
    (is_ctrl && prog_req.ctrl == osi_pkg::CTRL_READ && sec_word_q[osi_pkg::SEC_NO_TEST_OTP])
    |=> prog_rdata_q == 32'h0000_0000 && prog_err_q) else $error("otp read leaked");
  AST_DBG_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    sec_word_q[osi_pkg::SEC_NO_DEBUG_PIN] |=> !dbg_pin_oe_q && !debug_enter_q)
    else $error("debug pin active while disabled");
  AST_DBG_DRIVE: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(dbg_pin_oe_q) |-> $past(brk_hit) && !dbg_pin_o_q)
    else $error("debug pin driven without breakpoint");
  AST_TEST_PORT_IDENTIFICATION: assert property (@(posedge clk_sys) disable iff (rst)
    (tap_capture && tap_ir == osi_pkg::IR_TEST_PORT_IDENTIFICATION && trst_cnt_q == 8'(osi_pkg::TRST_MIN_CYC))
    |=> tap_dr_q[0]) else $error("test_port_identification bit 0 not one");
  AST_LOAD_FIRST: assert property (@(posedge clk_sys) disable iff (rst)
    !sec_ready_q |-> !copy_we_q && !copy_done_q) else $error("copy before security load");
  COV_COPY_DONE: cover property (@(posedge clk_sys) disable iff (rst) $rose(copy_done_q));
  COV_PROG_OK: cover property (@(posedge clk_sys) disable iff (rst)
    is_ctrl && prog_req.ctrl == osi_pkg::CTRL_PROG ##1 !prog_err_q);
  COV_DBG_IN: cover property (@(posedge clk_sys) disable iff (rst) debug_enter_q);
endmodule : osi_core

/* File: core/osi_pkg.sv */
// package: constants and carriers for the otp security and test id block
package osi_pkg;
  // ************************************
  // geometry
  // ************************************
  localparam int unsigned SECTORS = 4;
  localparam int unsigned ROWS_PER_SECTOR = 512;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 11; // sector(2) + row(9)
  // ************************************
  // resource identifiers of the programming ports
  // ************************************
  localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
  localparam logic [23:0] RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] RES_OTP_CTRL = 24'h100300;
  // ************************************
  // security word bit positions
  // ************************************
  localparam int unsigned SEC_NO_TEST = 0;
  localparam int unsigned SEC_NO_LINK = 1;
  localparam int unsigned SEC_SECURE_BOOT = 5;
  localparam int unsigned SEC_REDUNDANT = 7;
  localparam int unsigned SEC_SECTOR_LOCK_LO = 8;
  localparam int unsigned SEC_MASTER_LOCK = 12;
  localparam int unsigned SEC_NO_TEST_OTP = 13;
  localparam int unsigned SEC_NO_DEBUG_PIN = 14;
  localparam int unsigned SEC_GP_LO = 15;
  localparam int unsigned SEC_GP_HI = 21;
  localparam int unsigned SEC_USER_LO = 22;
  localparam int unsigned SEC_USER_HI = 31;
  // ************************************
  // control port encodings (16-bit control word)
  // ************************************
  localparam logic [15:0] CTRL_IDLE = 16'h0000;
  localparam logic [15:0] CTRL_READ = 16'h0001;
  localparam logic [15:0] CTRL_PROG = 16'h0002;
  localparam logic [15:0] CTRL_PROG_SEC = 16'h0004;
  // ************************************
  // reset values and timing
  // ************************************
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;
  localparam logic [3:0] IR_RESET = 4'h1; // test_port_identification selected after test reset
  localparam logic [3:0] IR_TEST_PORT_IDENTIFICATION = 4'h1;
  localparam logic [3:0] IR_USERCODE = 4'h8;
  localparam logic [3:0] IR_OTP_READ = 4'h4;
  localparam int unsigned TRST_MIN_NS = 100;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TRST_MIN_CYC = (TRST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RD_LAT = 1;
  // ************************************
  // identity fields (values arbitrary)
  // ************************************
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART = 16'h0a5c;
  localparam logic [10:0] ID_MAKER = 11'h2a5;
  localparam logic [15:0] SILICON_REV = 16'h0001;
  // ************************************
  // carriers
  // ************************************
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [31:0] data;
    logic [15:0] ctrl;
  } osi_prog_req_t;
  typedef struct packed {
    logic no_test;
    logic no_link;
    logic secure_boot;
    logic redundant;
    logic no_test_otp;
    logic no_debug_pin;
  } osi_gates_t;
endpackage : osi_pkg

/* File: sim/osi_host_model.sv */
// host-side model: otp programmer and test-port driver
module osi_host_model (
  input wire logic clk_sys, // tile clock
  input wire logic rst, // global reset
  output osi_pkg::osi_prog_req_t prog_req, // programming port write
  output logic [23:0] prog_res_id, // resource id of the port written
  output logic tap_trst_n, // test reset, low active
  output logic [3:0] tap_ir, // instruction
  output logic tap_capture, // capture strobe
  output logic tap_sel // boundary tap select
);
  timeunit 1ns;
  timeprecision 1ps;
  int trst_cnt;
  // ************************************
  // idle values at time zero
  // ************************************
  initial
  begin
    prog_req = '0;
    prog_res_id = 24'h000000;
    tap_trst_n = 1'b0;
    tap_ir = osi_pkg::IR_RESET;
    tap_capture = 1'b0;
    tap_sel = 1'b0;
  end
  // hold test reset low through reset and a margin after it
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      trst_cnt <= 0;
      tap_trst_n <= 1'b0;
    end
    else if (trst_cnt < osi_pkg::TRST_MIN_CYC + 2)
      trst_cnt <= trst_cnt + 1;
    else
      tap_trst_n <= 1'b1;
  end
  // one write to a programming port, only the addressed field changes
  task automatic port_write(input logic [23:0] res, input logic [31:0] val);
    @(posedge clk_sys);
    prog_res_id <= res;
    prog_req.valid <= 1'b1;
    if (res === osi_pkg::RES_OTP_ADDR)
      prog_req.addr <= val[15:0];
    else if (res === osi_pkg::RES_OTP_DATA)
      prog_req.data <= val;
    else
      prog_req.ctrl <= val[15:0];
  endtask : port_write
  // address, data, then control; on release address, data and resource id are inverted, control keeps its value
  task automatic command(input logic [15:0] addr, input logic [31:0] data, input logic [15:0] ctrl);
    port_write(osi_pkg::RES_OTP_ADDR, {16'h0000, addr});
    port_write(osi_pkg::RES_OTP_DATA, data);
    port_write(osi_pkg::RES_OTP_CTRL, {16'h0000, ctrl});
    @(posedge clk_sys);
    prog_req.valid <= 1'b0;
    prog_req.addr <= ~prog_req.addr;
    prog_req.data <= ~prog_req.data;
    prog_res_id <= ~prog_res_id;
    @(posedge clk_sys);
    #1;
  endtask : command
  // capture the data register under a given instruction
  task automatic capture(input logic [3:0] ir);
    @(posedge clk_sys);
    tap_ir <= ir;
    tap_capture <= 1'b1;
    @(posedge clk_sys);
    tap_capture <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : capture
endmodule : osi_host_model

/* File: sim/test_otp_security_and_test_id.sv */
// self-checking bench for the otp security and test id block
module test_otp_security_and_test_id;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SEC1 = {10'h2c3, 7'h55, 15'h01a2}; // link off, secure boot, redundant, sector 0 lock
  localparam logic [31:0] SEC2 = 32'h00007001; // test off, master lock, test otp off, pin off
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic tap_state_req = 1'b0;
  logic link_state_req = 1'b0;
  logic brk_hit = 1'b0;
  logic dbg_out_mode = 1'b0;
  logic dbg_in_mode = 1'b0;
  logic ext_low = 1'b0;
  osi_pkg::osi_prog_req_t prog_req;
  logic [23:0] prog_res_id;
  logic tap_trst_n, tap_capture, tap_sel;
  logic [3:0] tap_ir;
  logic dbg_pin_o_q, dbg_pin_oe_q, debug_enter_q, tap_grant_q, link_grant_q, sec_ready_q;
  logic boot_from_otp_q, boot_from_flash_q, copy_done_q, copy_we_q, prog_err_q;
  logic [31:0] tap_dr_q, sec_word_q, copy_data_q, prog_rdata_q;
  logic [15:0] copy_addr_q;
  int mismatches = 0;
  int comparisons = 0;
  int we_count = 0;
  // pulled-up debug pin, low when the tile or the far side pulls it down
  wire logic dbg_pin_i = ~((dbg_pin_oe_q & ~dbg_pin_o_q) | ext_low);
  always #2.5 clk_sys = ~clk_sys;
  // count words handed to sram since the last reset
  always @(posedge clk_sys)
    we_count <= rst ? 0 : we_count + int'(copy_we_q === 1'b1);
  // ************************************
  // instances
  // ************************************
  osi_core i_osi_core (.clk_sys(clk_sys), .rst(rst), .prog_req(prog_req), .prog_res_id(prog_res_id),
    .tap_trst_n(tap_trst_n), .tap_ir(tap_ir), .tap_capture(tap_capture), .tap_sel(tap_sel),
    .tap_state_req(tap_state_req), .link_state_req(link_state_req), .brk_hit(brk_hit),
    .dbg_out_mode(dbg_out_mode), .dbg_in_mode(dbg_in_mode), .dbg_pin_i(dbg_pin_i),
    .dbg_pin_o_q(dbg_pin_o_q), .dbg_pin_oe_q(dbg_pin_oe_q), .debug_enter_q(debug_enter_q),
    .tap_dr_q(tap_dr_q), .tap_grant_q(tap_grant_q), .link_grant_q(link_grant_q), .sec_word_q(sec_word_q),
    .sec_ready_q(sec_ready_q), .boot_from_otp_q(boot_from_otp_q), .boot_from_flash_q(boot_from_flash_q),
    .copy_done_q(copy_done_q), .copy_data_q(copy_data_q), .copy_addr_q(copy_addr_q), .copy_we_q(copy_we_q),
    .prog_rdata_q(prog_rdata_q), .prog_err_q(prog_err_q));
  osi_host_model i_osi_host_model (.clk_sys(clk_sys), .rst(rst), .prog_req(prog_req), .prog_res_id(prog_res_id),
    .tap_trst_n(tap_trst_n), .tap_ir(tap_ir), .tap_capture(tap_capture), .tap_sel(tap_sel));
  // ************************************
  // shared tasks
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  function automatic logic flag(input int k);
    case (k)
      0: return sec_ready_q;
      1: return copy_done_q;
      default: return debug_enter_q;
    endcase
  endfunction : flag
  // bounded wait on a completion flag; a required one that never comes ends the run
  task automatic wait_flag(input int k, input int lim, input bit must, output logic found);
    found = 1'b0;
    for (int i = 0; i < lim && !found; i++)
    begin
      @(posedge clk_sys);
      #1;
      found = (flag(k) === 1'b1);
    end
    if (must && !found)
    begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_flag
  // ************************************
  // scenarios
  // ************************************
  // power up: security word first, then the image copy, then the boot path
  task automatic power_up(input logic [31:0] exp_sec, input logic [31:0] exp_last);
    logic ok;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    wait_flag(0, 50, 1'b1, ok);
    check(copy_done_q, 1'b0);
    check(sec_word_q, exp_sec);
    wait_flag(1, 3000, 1'b1, ok);
    @(posedge clk_sys);
    #1;
    check(we_count, 32'd2048);
    check(copy_addr_q, 32'h000007ff);
    check(copy_data_q, exp_last);
    check({30'h0, boot_from_otp_q, boot_from_flash_q}, {30'h0, exp_sec[5], ~exp_sec[5]});
  endtask : power_up
  // identification and user code through the test port
  task automatic test_ids(input logic [31:0] sec);
    i_osi_host_model.capture(osi_pkg::IR_TEST_PORT_IDENTIFICATION);
    check(tap_dr_q, {osi_pkg::ID_VERSION, osi_pkg::ID_PART, osi_pkg::ID_MAKER, 1'b1});
    i_osi_host_model.capture(osi_pkg::IR_USERCODE);
    check(tap_dr_q, {sec[31:22], 6'h00, osi_pkg::SILICON_REV});
  endtask : test_ids
  // program a cell, then read it back
  task automatic prog_sector(input logic [15:0] addr, input logic [31:0] data, input logic err,
                             input logic [31:0] exp);
    i_osi_host_model.command(addr, data, osi_pkg::CTRL_PROG);
    check(prog_err_q, err);
    i_osi_host_model.command(addr, 32'h00000000, osi_pkg::CTRL_READ);
    check(prog_rdata_q, exp);
  endtask : prog_sector
  // state access from the test port and from other tiles
  task automatic access(input logic tap_ok, input logic link_ok);
    @(posedge clk_sys);
    tap_state_req <= 1'b1;
    link_state_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(tap_grant_q, tap_ok);
    check(link_grant_q, link_ok);
    @(posedge clk_sys);
    tap_state_req <= 1'b0;
    link_state_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({tap_grant_q, link_grant_q}, 2'b00);
  endtask : access
  // debug pin: input mode first, then output mode with a breakpoint
  task automatic debug_pin(input logic en);
    logic seen;
    @(posedge clk_sys);
    dbg_in_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ext_low <= 1'b1;
    wait_flag(2, 8, 1'b0, seen);
    check(seen, en);
    @(posedge clk_sys);
    ext_low <= 1'b0;
    dbg_in_mode <= 1'b0;
    dbg_out_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check(dbg_pin_oe_q, 1'b0);
    @(posedge clk_sys);
    brk_hit <= 1'b1;
    @(posedge clk_sys);
    brk_hit <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({dbg_pin_oe_q, dbg_pin_i}, {en, ~en});
    @(posedge clk_sys);
    dbg_out_mode <= 1'b0;
  endtask : debug_pin
  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    power_up(32'h00000000, 32'h00000000);
    test_ids(32'h00000000);
    access(1'b1, 1'b1);
    prog_sector(16'h0205, 32'h000000f0, 1'b0, 32'h000000f0);
    prog_sector(16'h0205, 32'h00000f00, 1'b0, 32'h00000ff0);
    prog_sector(16'h07ff, 32'h80000001, 1'b0, 32'h80000001);
    i_osi_host_model.capture(osi_pkg::IR_OTP_READ);
    check(tap_dr_q, 32'h80000001);
    i_osi_host_model.command(16'h0000, SEC1, osi_pkg::CTRL_PROG_SEC);
    check(sec_word_q, 32'h00000000);
    debug_pin(1'b1);
    power_up(SEC1, 32'h80000001);
    test_ids(SEC1);
    access(1'b1, 1'b0);
    prog_sector(16'h0003, 32'h00000005, 1'b1, 32'h00000000);
    prog_sector(16'h0403, 32'h00000005, 1'b0, 32'h00000005);
    // last row of sector 3 now lands in the redundant row
    prog_sector(16'h07ff, 32'h00000030, 1'b0, 32'h00000030);
    i_osi_host_model.command(16'h0000, SEC2, osi_pkg::CTRL_PROG_SEC);
    power_up(SEC1 | SEC2, 32'h80000001);
    access(1'b0, 1'b0);
    prog_sector(16'h0404, 32'h00000009, 1'b1, 32'h00000000);
    i_osi_host_model.command(16'h0205, 32'h00000000, osi_pkg::CTRL_READ);
    check(prog_rdata_q, 32'h00000000);
    i_osi_host_model.capture(osi_pkg::IR_OTP_READ);
    check(tap_dr_q, 32'h00000000);
    i_osi_host_model.command(16'h0000, 32'h00000040, osi_pkg::CTRL_PROG_SEC);
    check(prog_err_q, 1'b1);
    debug_pin(1'b0);
    power_up(SEC1 | SEC2, 32'h80000001);
    print_verdict();
  end
endmodule : test_otp_security_and_test_id
